// *** logic/timer_consts.svh ***
// register map, field positions and counts of the reload timers
// assumes byte-wide registers on a plain strobe port
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH
`define ADDR_TIMER0_COUNT_LOW    8'h13
`define ADDR_TIMER1_CONTROL      8'h14
`define ADDR_TIMER1_RELOAD_HIGH  8'h15
`define ADDR_TIMER1_RELOAD_LOW   8'h16
`define ADDR_TIMER1_COUNT_HIGH   8'h17
`define ADDR_TIMER1_COUNT_LOW    8'h18
`define ADDR_TIMER2_CONTROL      8'h19
`define ADDR_TIMER2_RELOAD_HIGH  8'h1A
`define ADDR_TIMER2_RELOAD_LOW   8'h1B
`define ADDR_TIMER2_COUNT_HIGH   8'h1C
`define ADDR_TIMER2_COUNT_LOW    8'h1D
`define ADDR_GLOBAL_CONTROL      8'h30
`define ADDR_UNDERFLOW_FLAGS     8'h31
`define CTL_STOP_RX              7
`define CTL_START_HI             5
`define CTL_START_LO             4
`define CTL_AUTO                 3
`define CTL_CLK_HI               1
`define CTL_CLK_LO               0
`define CTL_WRITE_MASK           8'hBB
`define GC_RUN_SEC               5
`define GC_RUN_THR               6
`define GC_NOW_SEC               1
`define GC_NOW_THR               2
`define FLAG_SEC                 0
`define FLAG_THR                 1
`define SLOW_DIVIDE              64
`define RX_STOP_BITS             3'h4
`define BYTE_ZERO                8'h00
`endif

// *** logic/timer_pkg.sv ***
// types shared by the reload timers
// assumes the constants header is included where numbers are needed
package timer_pkg;
	typedef enum logic [1:0] {
		START_NONE   = 2'h0,
		START_TX_END = 2'h1,
		TRIM_NO_UF   = 2'h2,
		TRIM_UF      = 2'h3
	} start_mode_t;
	typedef enum logic [1:0] {
		SRC_CARRIER  = 2'h0,
		SRC_SLOW     = 2'h1,
		SRC_FIRST_UF = 2'h2,
		SRC_PEER_UF  = 2'h3
	} clk_src_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_RUN  = 2'h2
	} timer_state_t;
endpackage

// *** logic/tick_divider.sv ***
// divides the carrier enable down to the slow count rate
// assumes tick_in is a one-cycle enable on clk
`timescale 1ns/10ps
module tick_divider #(
	parameter int DIV = 64
) (
	input  wire logic clk,      // core clock
	input  wire logic resetn,   // async reset, low
	input  wire logic tick_in,  // fast enable
	output logic      tick_out  // one pulse per DIV inputs
);
	localparam int CW = $clog2(DIV);
	logic [CW-1:0] cnt_q;

	if (DIV < 2) begin : bad_div
		$error("tick_divider needs DIV of at least 2");
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q    <= '0;
			tick_out <= 1'b0;
		end else begin
			tick_out <= tick_in && (cnt_q == CW'(DIV - 1));
			if (tick_in)
				cnt_q <= (cnt_q == CW'(DIV - 1)) ? '0 : cnt_q + CW'(1);
		end
	end
endmodule // tick_divider

// *** logic/count_unit.sv ***
// one down counter with start, stop, trim and reload behaviour
// assumes all event inputs are one-cycle pulses on clk
`timescale 1ns/10ps
module count_unit #(
	parameter int W = 16
) (
	input  wire logic         clk,          // core clock
	input  wire logic         resetn,       // async reset, low
	input  wire logic         tick,         // selected count enable
	input  wire logic [1:0]   start_mode,   // start mode field
	input  wire logic         stop_rx,      // stop after first rx bits
	input  wire logic         auto_reload,  // restart at underflow
	input  wire logic [W-1:0] reload_value, // reload registers
	input  wire logic         tx_end,       // end of transmission
	input  wire logic         rx_fourth,    // fourth bit of frame
	input  wire logic         lfo_rise,     // oscillator rising edge
	input  wire logic         sw_set,       // software start/stop now
	input  wire logic         sw_value,     // requested running state
	output logic [W-1:0]      count_q,      // current count
	output logic              running,      // running indicator
	output logic              underflow_q   // one-tick underflow pulse
);
	timer_pkg::timer_state_t state_q;
	logic [W-1:0] latched_q;
	logic trim, wrap, start_ev, stop_ev;

	if (W < 2 || W > 32) begin : bad_w
		$error("count_unit width out of range");
	end

	assign running  = (state_q == timer_pkg::ST_RUN);
	assign trim     = start_mode[1];
	// trim without underflow parks at zero instead of wrapping
	assign wrap     = running && tick && (count_q == '0)
	                  && (start_mode != timer_pkg::TRIM_NO_UF); // R16
	assign start_ev = ((start_mode == timer_pkg::START_TX_END) && tx_end) // R3
	                  || (trim && lfo_rise && !running) // R3
	                  || (sw_set && sw_value); // R15
	assign stop_ev  = (trim && lfo_rise && running) // R3
	                  || (!trim && stop_rx && rx_fourth) // R1 R2
	                  || (sw_set && !sw_value); // R15

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= timer_pkg::ST_IDLE;
		end else begin
			case (state_q)
				timer_pkg::ST_IDLE: begin
					if (start_ev)
						state_q <= timer_pkg::ST_RUN;
				end
				timer_pkg::ST_RUN: begin
					if (start_ev)
						state_q <= timer_pkg::ST_RUN;
					else if (stop_ev || (wrap && !auto_reload)) // R5
						state_q <= timer_pkg::ST_IDLE;
				end
				default: state_q <= timer_pkg::ST_IDLE;
			endcase
		end
	end

	// reload copy taken at start so later writes leave the run alone
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count_q   <= '0;
			latched_q <= '0;
		end else if (start_ev) begin
			count_q   <= reload_value; // R10
			latched_q <= reload_value; // R11
		end else if (wrap && auto_reload) begin
			count_q <= latched_q; // R4
		end else if (running && tick && count_q != '0) begin
			count_q <= count_q - W'(1); // R16
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			underflow_q <= 1'b0;
		else
			underflow_q <= wrap && !start_ev; // R16
	end
endmodule // count_unit

// *** logic/reload_timers.sv ***
// second and third reload timers with their register file
// assumes a plain strobe register port and synchronous event inputs
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
`include "timer_consts.svh"
// Notes on behaviour
// R1 - stop-on-receive set halts the timer after four received frame bits
// R2 - stop-on-receive has no effect in either trimming mode
// R3 - start mode: none, end of transmission, trim without or with underflow
// R4 - auto-reload set: reload at zero and keep counting
// R5 - auto-reload clear: stop at zero until the next start
// R6 - second timer underflow sets its flag
// R7 - third timer underflow sets its flag
// R8 - second timer source: carrier, slow, first or third timer underflow
// R9 - third timer source: carrier, slow, first or second timer underflow
// R10 - each start loads the counter from both reload bytes
// R11 - reload writes change nothing until the next start
// R12 - count high and low bytes are read-only live values
// R13 - host must not read counts while a frame is received
// R14 - first timer count low byte is readable
// R15 - running bit changes only with its start-stop-now bit
// R16 - decrement per tick; passing zero gives a one-tick underflow
module reload_timers #(
	parameter int W = 16
) (
	input  wire logic       core_clk,                        // 10 MHz clock
	input  wire logic       resetn,                          // async reset, low
	input  wire logic [7:0] addr,                            // register address
	input  wire logic [7:0] wr_data,                         // write data
	input  wire logic       wr_en,                           // write strobe
	input  wire logic       rd_en,                           // read strobe
	output logic      [7:0] rd_data_q,                       // read data, next cycle
	input  wire logic       carrier_tick,                    // carrier rate enable
	input  wire logic       tx_end,                          // transmission ended
	input  wire logic       rx_active,                       // frame reception level
	input  wire logic       rx_bit,                          // one received bit
	input  wire logic       lfo_in,                          // oscillator level
	input  wire logic       first_timer_underflow,           // first timer pulse
	input  wire logic [7:0] first_timer_count_low_byte,      // first timer count
	output logic            second_timer_underflow_flag,     // sticky flag
	output logic            third_timer_underflow_flag,      // sticky flag
	output logic            second_timer_running_indicator,  // timer running
	output logic            third_timer_running_indicator    // timer running
);
	logic [7:0]   ctl_sec_q, ctl_thr_q;
	logic [7:0]   rld_sec_hi_q, rld_sec_lo_q;
	logic [7:0]   rld_thr_hi_q, rld_thr_lo_q;
	logic [1:0]   flag_q;
	logic [2:0]   rx_cnt_q;
	logic         lfo_q;
	logic         run_sec_q, run_thr_q;
	logic         slow_tick, lfo_rise, rx_fourth;
	logic         gc_wr, now_sec, now_thr;
	logic         sec_tick, thr_tick, sec_uf, thr_uf;
	logic         sec_run, thr_run;
	logic [W-1:0] sec_cnt, thr_cnt;
	logic [7:0]   rd_mux;

	function automatic logic src_tick(input logic [1:0] sel, input logic fast,
	                                  input logic slow, input logic first_uf,
	                                  input logic peer_uf);
		case (sel)
			timer_pkg::SRC_CARRIER:  src_tick = fast;
			timer_pkg::SRC_SLOW:     src_tick = slow;
			timer_pkg::SRC_FIRST_UF: src_tick = first_uf;
			timer_pkg::SRC_PEER_UF:  src_tick = peer_uf;
			default:                 src_tick = 1'b0;
		endcase
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
		hit = (a == ref_a);
	endfunction

	if (W != 16) begin : bad_w
		$error("reload_timers maps exactly two count bytes");
	end

	// slow rate is the carrier divided by 64
	tick_divider #(
		.DIV (`SLOW_DIVIDE)
	) u_div (
		.clk      (core_clk),
		.resetn   (resetn),
		.tick_in  (carrier_tick),
		.tick_out (slow_tick)
	);

	assign lfo_rise  = lfo_in && !lfo_q;
	assign rx_fourth = rx_active && rx_bit && (rx_cnt_q == `RX_STOP_BITS - 3'h1); // R1
	assign gc_wr     = wr_en && hit(addr, `ADDR_GLOBAL_CONTROL);
	assign now_sec   = gc_wr && wr_data[`GC_NOW_SEC]; // R15
	assign now_thr   = gc_wr && wr_data[`GC_NOW_THR]; // R15
	// underflows are registered, so mutual cascading cannot loop
	assign sec_tick  = src_tick(ctl_sec_q[`CTL_CLK_HI:`CTL_CLK_LO], carrier_tick,
	                            slow_tick, first_timer_underflow, thr_uf); // R8
	assign thr_tick  = src_tick(ctl_thr_q[`CTL_CLK_HI:`CTL_CLK_LO], carrier_tick,
	                            slow_tick, first_timer_underflow, sec_uf); // R9

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			lfo_q    <= 1'b0;
			rx_cnt_q <= 3'h0;
		end else begin
			lfo_q <= lfo_in;
			if (!rx_active)
				rx_cnt_q <= 3'h0;
			else if (rx_bit && rx_cnt_q != `RX_STOP_BITS)
				rx_cnt_q <= rx_cnt_q + 3'h1;
		end
	end

	count_unit #(
		.W (W)
	) u_sec (
		.clk          (core_clk),
		.resetn       (resetn),
		.tick         (sec_tick),
		.start_mode   (ctl_sec_q[`CTL_START_HI:`CTL_START_LO]),
		.stop_rx      (ctl_sec_q[`CTL_STOP_RX]),
		.auto_reload  (ctl_sec_q[`CTL_AUTO]),
		.reload_value ({rld_sec_hi_q, rld_sec_lo_q}),
		.tx_end       (tx_end),
		.rx_fourth    (rx_fourth),
		.lfo_rise     (lfo_rise),
		.sw_set       (now_sec),
		.sw_value     (wr_data[`GC_RUN_SEC]),
		.count_q      (sec_cnt),
		.running      (sec_run),
		.underflow_q  (sec_uf)
	);

	count_unit #(
		.W (W)
	) u_thr (
		.clk          (core_clk),
		.resetn       (resetn),
		.tick         (thr_tick),
		.start_mode   (ctl_thr_q[`CTL_START_HI:`CTL_START_LO]),
		.stop_rx      (ctl_thr_q[`CTL_STOP_RX]),
		.auto_reload  (ctl_thr_q[`CTL_AUTO]),
		.reload_value ({rld_thr_hi_q, rld_thr_lo_q}),
		.tx_end       (tx_end),
		.rx_fourth    (rx_fourth),
		.lfo_rise     (lfo_rise),
		.sw_set       (now_thr),
		.sw_value     (wr_data[`GC_RUN_THR]),
		.count_q      (thr_cnt),
		.running      (thr_run),
		.underflow_q  (thr_uf)
	);

	// control and reload registers; reserved bits never store
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ctl_sec_q    <= `BYTE_ZERO;
			ctl_thr_q    <= `BYTE_ZERO;
			rld_sec_hi_q <= `BYTE_ZERO;
			rld_sec_lo_q <= `BYTE_ZERO;
			rld_thr_hi_q <= `BYTE_ZERO;
			rld_thr_lo_q <= `BYTE_ZERO;
		end else if (wr_en) begin
			if (hit(addr, `ADDR_TIMER1_CONTROL))
				ctl_sec_q <= wr_data & `CTL_WRITE_MASK;
			if (hit(addr, `ADDR_TIMER2_CONTROL))
				ctl_thr_q <= wr_data & `CTL_WRITE_MASK;
			if (hit(addr, `ADDR_TIMER1_RELOAD_HIGH))
				rld_sec_hi_q <= wr_data; // R11
			if (hit(addr, `ADDR_TIMER1_RELOAD_LOW))
				rld_sec_lo_q <= wr_data; // R11
			if (hit(addr, `ADDR_TIMER2_RELOAD_HIGH))
				rld_thr_hi_q <= wr_data;
			if (hit(addr, `ADDR_TIMER2_RELOAD_LOW))
				rld_thr_lo_q <= wr_data;
		end
	end

	// write one clears; an underflow in the same cycle wins
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			flag_q <= 2'h0;
		end else begin
			if (sec_uf)
				flag_q[`FLAG_SEC] <= 1'b1; // R6
			else if (wr_en && hit(addr, `ADDR_UNDERFLOW_FLAGS) && wr_data[`FLAG_SEC])
				flag_q[`FLAG_SEC] <= 1'b0;
			if (thr_uf)
				flag_q[`FLAG_THR] <= 1'b1; // R7
			else if (wr_en && hit(addr, `ADDR_UNDERFLOW_FLAGS) && wr_data[`FLAG_THR])
				flag_q[`FLAG_THR] <= 1'b0;
		end
	end

	// outputs held in flops so they are clean from reset on
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			run_sec_q                   <= 1'b0;
			run_thr_q                   <= 1'b0;
			second_timer_underflow_flag <= 1'b0;
			third_timer_underflow_flag  <= 1'b0;
		end else begin
			run_sec_q                   <= sec_run;
			run_thr_q                   <= thr_run;
			second_timer_underflow_flag <= flag_q[`FLAG_SEC] || sec_uf;
			third_timer_underflow_flag  <= flag_q[`FLAG_THR] || thr_uf;
		end
	end
	assign second_timer_running_indicator = run_sec_q;
	assign third_timer_running_indicator  = run_thr_q;

	always_comb begin
		rd_mux = `BYTE_ZERO;
		case (addr)
			`ADDR_TIMER0_COUNT_LOW:   rd_mux = first_timer_count_low_byte; // R14
			`ADDR_TIMER1_CONTROL:     rd_mux = ctl_sec_q;
			`ADDR_TIMER1_RELOAD_HIGH: rd_mux = rld_sec_hi_q;
			`ADDR_TIMER1_RELOAD_LOW:  rd_mux = rld_sec_lo_q;
			`ADDR_TIMER1_COUNT_HIGH:  rd_mux = sec_cnt[15:8]; // R12
			`ADDR_TIMER1_COUNT_LOW:   rd_mux = sec_cnt[7:0]; // R12
			`ADDR_TIMER2_CONTROL:     rd_mux = ctl_thr_q;
			`ADDR_TIMER2_RELOAD_HIGH: rd_mux = rld_thr_hi_q;
			`ADDR_TIMER2_RELOAD_LOW:  rd_mux = rld_thr_lo_q;
			`ADDR_TIMER2_COUNT_HIGH:  rd_mux = thr_cnt[15:8]; // R12
			`ADDR_TIMER2_COUNT_LOW:   rd_mux = thr_cnt[7:0]; // R12
			`ADDR_GLOBAL_CONTROL: begin
				rd_mux[`GC_RUN_SEC] = sec_run; // R15
				rd_mux[`GC_RUN_THR] = thr_run; // R15
			end
			`ADDR_UNDERFLOW_FLAGS:    rd_mux = {6'h00, flag_q};
			default:                  rd_mux = `BYTE_ZERO;
		endcase
	end

	// count bytes are live, so a high then low read may tear mid count
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			rd_data_q <= `BYTE_ZERO;
		else
			rd_data_q <= rd_en ? rd_mux : `BYTE_ZERO;
	end

	logic quiet;
	assign quiet = !tx_end && !lfo_rise && !gc_wr;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	rx_stop_a: assert property ( // R1
		sec_run && quiet && ctl_sec_q[`CTL_STOP_RX] && !ctl_sec_q[`CTL_START_HI] && rx_fourth
		|=> !sec_run ##1 !run_sec_q)
		else $error("second timer kept running after four rx bits");

	trim_ignores_rx_a: assert property ( // R2
		sec_run && quiet && ctl_sec_q[`CTL_START_HI] && rx_fourth && sec_cnt != '0
		|=> sec_run)
		else $error("stop on receive acted in a trimming mode");

	tx_start_a: assert property ( // R3
		ctl_sec_q[`CTL_START_HI:`CTL_START_LO] == timer_pkg::START_TX_END && tx_end && !gc_wr
		|=> sec_run && sec_cnt == $past({rld_sec_hi_q, rld_sec_lo_q}))
		else $error("end of transmission did not load and start");

	auto_reload_a: assert property ( // R4
		sec_run && quiet && !rx_fourth && sec_tick && sec_cnt == '0 && ctl_sec_q[`CTL_AUTO]
		&& ctl_sec_q[`CTL_START_HI:`CTL_START_LO] != timer_pkg::TRIM_NO_UF
		|=> sec_run && sec_uf)
		else $error("auto reload did not keep the timer running");

	halt_at_zero_a: assert property ( // R5
		thr_run && quiet && thr_tick && thr_cnt == '0 && !ctl_thr_q[`CTL_AUTO]
		&& ctl_thr_q[`CTL_START_HI:`CTL_START_LO] != timer_pkg::TRIM_NO_UF
		|=> !thr_run && thr_cnt == '0)
		else $error("timer without auto reload did not halt at zero");

	sec_flag_a: assert property ( // R6
		sec_uf |=> flag_q[`FLAG_SEC] ##1 second_timer_underflow_flag)
		else $error("second underflow flag not set");

	thr_flag_a: assert property ( // R7
		thr_uf |=> flag_q[`FLAG_THR] ##1 third_timer_underflow_flag)
		else $error("third underflow flag not set");

	carrier_count_a: assert property ( // R8
		sec_run && quiet && !rx_fourth && ctl_sec_q[`CTL_CLK_HI:`CTL_CLK_LO] == timer_pkg::SRC_CARRIER
		&& carrier_tick && sec_cnt != '0
		|=> sec_cnt == $past(sec_cnt) - 16'h0001)
		else $error("second timer missed a carrier tick");

	cascade_count_a: assert property ( // R9
		thr_run && quiet && !rx_fourth && ctl_thr_q[`CTL_CLK_HI:`CTL_CLK_LO] == timer_pkg::SRC_PEER_UF
		&& !sec_uf && !slow_tick
		|=> thr_cnt == $past(thr_cnt))
		else $error("third timer counted without a second timer underflow");

	reload_hold_a: assert property ( // R11
		sec_run && quiet && !sec_tick && !rx_fourth && wr_en && hit(addr, `ADDR_TIMER1_RELOAD_LOW)
		|=> sec_cnt == $past(sec_cnt))
		else $error("reload write disturbed the running count");

	count_read_a: assert property ( // R12
		rd_en && addr == `ADDR_TIMER1_COUNT_LOW |=> rd_data_q == $past(sec_cnt[7:0]))
		else $error("count low byte read back wrong");

	now_bit_a: assert property ( // R15
		gc_wr && !wr_data[`GC_NOW_THR] && !thr_tick && !tx_end && !lfo_rise && !rx_fourth
		|=> thr_run == $past(thr_run))
		else $error("running bit changed without its start-stop-now bit");

	trim_park_a: assert property ( // R3
		sec_run && quiet && !rx_fourth && sec_tick && sec_cnt == '0
		&& ctl_sec_q[`CTL_START_HI:`CTL_START_LO] == timer_pkg::TRIM_NO_UF
		|=> sec_run && !sec_uf && sec_cnt == '0)
		else $error("trimming without underflow did not park at zero");

	thr_reload_a: assert property ( // R4
		thr_run && quiet && !rx_fourth && thr_tick && thr_cnt == '0 && ctl_thr_q[`CTL_AUTO]
		&& ctl_thr_q[`CTL_START_HI:`CTL_START_LO] != timer_pkg::TRIM_NO_UF
		|=> thr_run && thr_uf)
		else $error("third timer did not reload at zero");

	flag_clear_a: assert property ( // R6
		wr_en && hit(addr, `ADDR_UNDERFLOW_FLAGS) && wr_data[`FLAG_SEC] && !sec_uf
		|=> !flag_q[`FLAG_SEC])
		else $error("second underflow flag did not clear");

	high_byte_read_a: assert property ( // R12
		rd_en && addr == `ADDR_TIMER2_COUNT_HIGH |=> rd_data_q == $past(thr_cnt[15:8]))
		else $error("third count high byte read back wrong");

	first_count_read_a: assert property ( // R14
		rd_en && addr == `ADDR_TIMER0_COUNT_LOW |=> rd_data_q == $past(first_timer_count_low_byte))
		else $error("first timer count byte read back wrong");

	run_read_a: assert property ( // R15
		rd_en && addr == `ADDR_GLOBAL_CONTROL |=> rd_data_q[`GC_RUN_SEC] == $past(sec_run))
		else $error("running bit read back wrong");

	cascade_c: cover property (sec_uf && ctl_thr_q[`CTL_CLK_HI:`CTL_CLK_LO] == timer_pkg::SRC_PEER_UF);
	rx_stop_c: cover property (sec_run && rx_fourth && ctl_sec_q[`CTL_STOP_RX] ##1 !sec_run);
	trim_c:    cover property (lfo_rise && thr_run && ctl_thr_q[`CTL_START_HI]);
	clear_c:   cover property (wr_en && hit(addr, `ADDR_UNDERFLOW_FLAGS) && flag_q != 2'h0);
endmodule // reload_timers

// *** sim/tb_reload_timers.sv ***
// self-checking bench for the second and third reload timers
// assumes the register port and event inputs of reload_timers, nothing else around it
`timescale 1ns/10ps
`include "timer_consts.svh"
module tb_reload_timers;
	logic       core_clk;
	logic       resetn;
	logic [7:0] addr;
	logic [7:0] wr_data;
	logic       wr_en;
	logic       rd_en;
	logic [7:0] rd_data_q;
	logic       carrier_tick;
	logic       tx_end;
	logic       rx_active;
	logic       rx_bit;
	logic       lfo_in;
	logic       first_timer_underflow;
	logic [7:0] first_timer_count_low_byte;
	logic       second_timer_underflow_flag;
	logic       third_timer_underflow_flag;
	logic       second_timer_running_indicator;
	logic       third_timer_running_indicator;
	int         bad_count;
	int         n_checks;
	logic [7:0] r;

	reload_timers reload_timers_i (
		.core_clk                       (core_clk),
		.resetn                         (resetn),
		.addr                           (addr),
		.wr_data                        (wr_data),
		.wr_en                          (wr_en),
		.rd_en                          (rd_en),
		.rd_data_q                      (rd_data_q),
		.carrier_tick                   (carrier_tick),
		.tx_end                         (tx_end),
		.rx_active                      (rx_active),
		.rx_bit                         (rx_bit),
		.lfo_in                         (lfo_in),
		.first_timer_underflow          (first_timer_underflow),
		.first_timer_count_low_byte     (first_timer_count_low_byte),
		.second_timer_underflow_flag    (second_timer_underflow_flag),
		.third_timer_underflow_flag     (third_timer_underflow_flag),
		.second_timer_running_indicator (second_timer_running_indicator),
		.third_timer_running_indicator  (third_timer_running_indicator)
	);

	always #50 core_clk = ~core_clk;

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t pin got=%h exp=%h", $time, got, exp);
		end
	endtask

	// extra idle edges let the one-cycle-late indicators settle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge core_clk);
		wr_en <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge core_clk);
		rd_en <= 1'b0;
		#1 d = rd_data_q;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
		logic [7:0] h;
		logic [7:0] l;
		rd(a, h);
		rd(a + 8'h01, l);
		chk({h, l}, exp);
	endtask

	// kinds: 0 carrier tick, 1 end of tx, 2 rx bit, 3 first timer underflow, 4 oscillator rise
	task automatic ev(input int k);
		@(posedge core_clk);
		case (k)
			0: carrier_tick <= 1'b1;
			1: tx_end <= 1'b1;
			2: rx_bit <= 1'b1;
			3: first_timer_underflow <= 1'b1;
			default: lfo_in <= 1'b1;
		endcase
		@(posedge core_clk);
		carrier_tick <= 1'b0;
		tx_end <= 1'b0;
		rx_bit <= 1'b0;
		first_timer_underflow <= 1'b0;
		lfo_in <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask

	initial begin
		#2000000;
		bad_count++;
		tally_and_finish();
	end

	initial begin
		core_clk = 1'b0;
		resetn = 1'b0;
		addr = 8'h00;
		wr_data = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
		carrier_tick = 1'b0;
		tx_end = 1'b0;
		rx_active = 1'b0;
		rx_bit = 1'b0;
		lfo_in = 1'b0;
		first_timer_underflow = 1'b0;
		first_timer_count_low_byte = 8'h5A;
		bad_count = 0;
		n_checks = 0;
		repeat (20) @(posedge core_clk);
		resetn <= 1'b1;

		rdc(`ADDR_TIMER1_COUNT_HIGH, 16'h0000);
		wr(`ADDR_TIMER1_COUNT_LOW, 8'hFF);
		rdc(`ADDR_TIMER1_COUNT_HIGH, 16'h0000);
		rd(`ADDR_TIMER0_COUNT_LOW, r);
		chk({8'h00, r}, 16'h005A);
		rd(8'h40, r);
		chk({8'h00, r}, 16'h0000);
		wr(`ADDR_TIMER1_CONTROL, 8'hFF);
		rd(`ADDR_TIMER1_CONTROL, r);
		chk({8'h00, r}, 16'h00BB);
		wr(`ADDR_TIMER1_CONTROL, 8'h00);
		ev(1);
		chk1(second_timer_running_indicator, 1'b0);
		$display("test map done");

		wr(`ADDR_TIMER1_RELOAD_HIGH, 8'h00);
		wr(`ADDR_TIMER1_RELOAD_LOW, 8'h02);
		wr(`ADDR_TIMER1_CONTROL, 8'h18);
		ev(1);
		rdc(`ADDR_TIMER1_COUNT_HIGH, 16'h0002);
		ev(0);
		rdc(`ADDR_TIMER1_COUNT_HIGH, 16'h0001);
		ev(0);
		rdc(`ADDR_TIMER1_COUNT_HIGH, 16'h0000);
		ev(0);
		rdc(`ADDR_TIMER1_COUNT_HIGH, 16'h0002);
		chk1(second_timer_underflow_flag, 1'b1);
		rd(`ADDR_UNDERFLOW_FLAGS, r);
		chk({8'h00, r}, 16'h0001);
		wr(`ADDR_TIMER1_RELOAD_LOW, 8'h05);
		ev(0);
		rdc(`ADDR_TIMER1_COUNT_HIGH, 16'h0001);
		wr(`ADDR_UNDERFLOW_FLAGS, 8'h01);
		rd(`ADDR_UNDERFLOW_FLAGS, r);
		chk({8'h00, r}, 16'h0000);
		$display("test auto reload done");

		wr(`ADDR_TIMER1_CONTROL, 8'h10);
		ev(1);
		rdc(`ADDR_TIMER1_COUNT_HIGH, 16'h0005);
		repeat (7) ev(0);
		rdc(`ADDR_TIMER1_COUNT_HIGH, 16'h0000);
		chk1(second_timer_running_indicator, 1'b0);
		$display("test single shot done");

		wr(`ADDR_GLOBAL_CONTROL, 8'h20);
		chk1(second_timer_running_indicator, 1'b0);
		wr(`ADDR_GLOBAL_CONTROL, 8'h22);
		chk1(second_timer_running_indicator, 1'b1);
		rdc(`ADDR_TIMER1_COUNT_HIGH, 16'h0005);
		rd(`ADDR_GLOBAL_CONTROL, r);
		chk({8'h00, r}, 16'h0020);
		wr(`ADDR_GLOBAL_CONTROL, 8'h02);
		chk1(second_timer_running_indicator, 1'b0);
		$display("test global control done");

		for (int s = 0; s < 2; s++) begin
			wr(`ADDR_TIMER1_CONTROL, (s == 1) ? 8'h90 : 8'h10);
			ev(1);
			@(posedge core_clk);
			rx_active <= 1'b1;
			repeat (3) ev(2);
			chk1(second_timer_running_indicator, 1'b1);
			ev(2);
			chk1(second_timer_running_indicator, s != 1);
			rx_active <= 1'b0;
			ev(0);
			rdc(`ADDR_TIMER1_COUNT_HIGH, (s == 1) ? 16'h0005 : 16'h0004);
		end
		$display("test stop on receive done");

		// auto reload kept on so an underflow never idles the timer before the stop edge
		wr(`ADDR_TIMER1_RELOAD_LOW, 8'h01);
		for (int m = 2; m < 4; m++) begin
			wr(`ADDR_UNDERFLOW_FLAGS, 8'h03);
			wr(`ADDR_TIMER1_CONTROL, 8'h88 | 8'(m << 4));
			ev(4);
			chk1(second_timer_running_indicator, 1'b1);
			@(posedge core_clk);
			rx_active <= 1'b1;
			repeat (4) ev(2);
			rx_active <= 1'b0;
			chk1(second_timer_running_indicator, 1'b1);
			repeat (2) ev(0);
			chk1(second_timer_underflow_flag, m == 3);
			ev(4);
			chk1(second_timer_running_indicator, 1'b0);
		end
		$display("test trimming done");

		wr(`ADDR_TIMER1_CONTROL, 8'h0A);
		wr(`ADDR_GLOBAL_CONTROL, 8'h22);
		ev(3);
		rdc(`ADDR_TIMER1_COUNT_HIGH, 16'h0000);
		wr(`ADDR_TIMER1_CONTROL, 8'h08);
		wr(`ADDR_GLOBAL_CONTROL, 8'h22);
		wr(`ADDR_TIMER2_RELOAD_HIGH, 8'h00);
		wr(`ADDR_TIMER2_RELOAD_LOW, 8'h01);
		// second timer underflows on every other carrier tick, so sources stay distinguishable
		for (int src = 0; src < 4; src++) begin
			wr(`ADDR_TIMER2_CONTROL, 8'h08 | 8'(src));
			wr(`ADDR_GLOBAL_CONTROL, 8'h44);
			repeat ((src == 1) ? 64 : ((src == 3) ? 2 : 1)) ev((src == 2) ? 3 : 0);
			rdc(`ADDR_TIMER2_COUNT_HIGH, 16'h0000);
		end
		repeat (2) ev(0);
		chk1(third_timer_underflow_flag, 1'b1);
		// third timer single shot on the carrier
		wr(`ADDR_TIMER2_CONTROL, 8'h00);
		wr(`ADDR_GLOBAL_CONTROL, 8'h44);
		chk1(third_timer_running_indicator, 1'b1);
		repeat (2) ev(0);
		chk1(third_timer_running_indicator, 1'b0);
		rdc(`ADDR_TIMER2_COUNT_HIGH, 16'h0000);
		$display("test clock sources done");
		tally_and_finish();
	end
endmodule // tb_reload_timers
